// ---- src/sar_readout_pkg.sv ----
// Constants and types for the converter result readout
// Operation
// R1: Format pin high gives straight binary, low twos
// R2: Parallel reads keep register; serial clocks shift
// R3: Host reads parallel before serial, never reverse
// R4: Parallel use: external select high, clock low
// R5: Bus driven only when read high, select low
// R6: Byte low gives top eight; high low four
// R7: Byte select toggles presented byte within conversion
// R8: Output content undefined before first conversion
// R9: Register updates first, then busy rises
// R10: Previous result kept twelve microseconds after start
// R11: Host avoids reads from twelve microseconds on
// R12: Internal mode drives clock, shifts previous result
// R13: External mode: clock pin is an input
// R14: External, busy high: select fall shifts result; code shifts on the second and later data clock rises instead
// R15: External, busy low: read enable shifts previous
// R16: Both low at busy rise restarts conversion
// R17: Commands ignored while conversion in progress
// R18: Codes: twos complement, binary inverts MSB
// R19: Busy low from start until register updated
// R20: Start is level sensitive, both inputs low
// R21: Internal mode sends MSB first, twelve pulses
// R22: Result held until next load or shift
package sar_readout_pkg;
    localparam int RES_W           = 12;
    localparam int BYTE_W          = 8;
    localparam int CNT_W           = 8;
    localparam int BIT_W           = 4;
    localparam int PIN_W           = 6;
    localparam int MSB_POS         = 11;
    localparam int CLK_PERIOD_NS   = 100;
    localparam int CONV_TIME_NS    = 14700;
    localparam int PREV_HOLD_NS    = 12000;
    localparam int DCLK_DELAY_NS   = 1400;
    localparam int DCLK_PERIOD_NS  = 1100;
    localparam int DCLK_HIGH_NS    = 500;
    localparam int CONV_CYCLES     = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HOLD_CYCLES     = (PREV_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DCLK_DELAY_CYC  = (DCLK_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DCLK_PERIOD_CYC = DCLK_PERIOD_NS / CLK_PERIOD_NS;
    localparam int DCLK_HIGH_CYC   = (DCLK_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DCLK_PULSES     = 12;
    localparam logic [CNT_W-1:0] CONV_LAST    = CNT_W'(CONV_CYCLES - 1);
    localparam logic [CNT_W-1:0] HOLD_CNT     = CNT_W'(HOLD_CYCLES);
    localparam logic [CNT_W-1:0] DCLK_DELAY   = CNT_W'(DCLK_DELAY_CYC);
    localparam logic [BIT_W-1:0] DCLK_PH_LAST = BIT_W'(DCLK_PERIOD_CYC - 1);
    localparam logic [BIT_W-1:0] DCLK_HIGH    = BIT_W'(DCLK_HIGH_CYC);
    localparam logic [BIT_W-1:0] DCLK_NUM     = BIT_W'(DCLK_PULSES);
    localparam logic [RES_W-1:0] RESULT_RST   = 12'h000;
    // Order: cs_n, rd_conv, byte_sel, format, source, data clock
    localparam logic [PIN_W-1:0] PIN_SYNC_RST = 6'h32;
    typedef enum logic [1:0] {
        ST_IDLE   = 2'h0,
        ST_CONV   = 2'h1,
        ST_UPDATE = 2'h3
    } conv_state_t;
endpackage

// ---- src/result_if.sv ----
// Interface between readout control and the output register
`timescale 1ns/1ps
interface result_if;
    logic        load;
    logic [11:0] load_data;
    logic        shift;
    logic        shift_in;
    logic [11:0] data;
    modport ctrl  (output load, output load_data, output shift, output shift_in, input data);
    modport store (input load, input load_data, input shift, input shift_in, output data);
endinterface

// ---- src/result_reg.sv ----
// Output register holding one result, loadable and shiftable
`timescale 1ns/1ps
module result_reg (
    // Clock and reset
    input  wire logic i_clk,
    input  wire logic i_srst,
    // Control
    result_if.store   rif
);
    // Load beats shift: a new result must not be lost to a clock edge
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            rif.data <= sar_readout_pkg::RESULT_RST; // R8
        end else if (rif.load) begin
            rif.data <= rif.load_data; // R22
        end else if (rif.shift) begin
            rif.data <= {rif.data[10:0], rif.shift_in}; // R2
        end
    end
endmodule

// ---- src/sar_adc_result_readout.sv ----
// Conversion control and parallel/serial result readout
`timescale 1ns/1ps
module sar_adc_result_readout (
    // Clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_srst,
    // Host control pins
    input  wire logic        i_cs_n,
    input  wire logic        i_rd_conv,
    input  wire logic        i_byte_sel,
    input  wire logic        i_output_format_select,
    input  wire logic        i_data_clock_source_select,
    // Serial data clock pin and serial data output
    input  wire logic        i_serial_data_clock,
    output logic             o_serial_data_clock,
    output logic             o_serial_data_clock_oe_n,
    output logic             o_serial_data_out,
    // Parallel bus
    output logic [7:0]       o_parallel_data_bus,
    output logic             o_parallel_data_bus_oe_n,
    // Status
    output logic             o_busy_n,
    // Converter core result, twos complement
    input  wire logic [11:0] i_conv_code
);
    localparam int PW = sar_readout_pkg::PIN_W;
    localparam int CW = sar_readout_pkg::CNT_W;
    localparam int BW = sar_readout_pkg::BIT_W;

    logic [PW-1:0]                   sync1_r;
    logic [PW-1:0]                   sync2_r;
    logic                            cs_n_s;
    logic                            rc_s;
    logic                            byte_s;
    logic                            fmt_s;
    logic                            src_s;
    logic                            dclk_s;
    logic                            dclk_d_r;
    logic                            dclk_rise;
    logic                            conv_req;
    logic                            read_en;
    logic                            ext_rd;
    logic                            first_r;
    logic                            int_mode_r;
    logic                            int_active;
    logic                            int_shift;
    logic                            ext_shift;
    logic [CW-1:0]                   cnt_r;
    logic [BW-1:0]                   phase_r;
    logic [BW-1:0]                   bits_r;
    logic                            dclk_out_r;
    logic [7:0]                      par_r;
    logic                            par_oe_n_r;
    sar_readout_pkg::conv_state_t    state_r;

    result_if rif ();

    result_reg u_result (
        .i_clk  (i_clk),
        .i_srst (i_srst),
        .rif    (rif)
    );

    // Pin synchronisers; only the second stage is read
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            sync1_r <= sar_readout_pkg::PIN_SYNC_RST;
            sync2_r <= sar_readout_pkg::PIN_SYNC_RST;
        end else begin
            sync1_r <= {i_cs_n, i_rd_conv, i_byte_sel, i_output_format_select,
                        i_data_clock_source_select, i_serial_data_clock};
            sync2_r <= sync1_r;
        end
    end

    assign cs_n_s = sync2_r[5];
    assign rc_s   = sync2_r[4];
    assign byte_s = sync2_r[3];
    assign fmt_s  = sync2_r[2];
    assign src_s  = sync2_r[1];
    assign dclk_s = sync2_r[0];

    assign conv_req = ~cs_n_s & ~rc_s; // R20
    assign read_en  = ~cs_n_s & rc_s;
    assign ext_rd   = read_en & src_s; // R14 R15

    // Conversion sequencer
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            state_r    <= sar_readout_pkg::ST_IDLE;
            cnt_r      <= '0;
            int_mode_r <= 1'h0;
        end else begin
            case (state_r)
                sar_readout_pkg::ST_IDLE: begin
                    // Level sensitive: both low at busy rise restarts at once
                    if (conv_req) begin // R16 R20
                        state_r    <= sar_readout_pkg::ST_CONV;
                        cnt_r      <= '0;
                        int_mode_r <= ~src_s; // R12 R13
                    end
                end
                sar_readout_pkg::ST_CONV: begin
                    // Commands are not looked at until busy rises
                    cnt_r <= cnt_r + CW'(1); // R17
                    if (cnt_r == sar_readout_pkg::CONV_LAST) begin
                        state_r <= sar_readout_pkg::ST_UPDATE;
                    end
                end
                sar_readout_pkg::ST_UPDATE: begin
                    state_r <= sar_readout_pkg::ST_IDLE; // R9
                end
                default: begin
                    state_r <= sar_readout_pkg::ST_IDLE;
                end
            endcase
        end
    end

    assign o_busy_n = (state_r == sar_readout_pkg::ST_IDLE); // R19

    // Result loads on the last conversion cycle, after the hold window
    assign rif.load      = (state_r == sar_readout_pkg::ST_CONV) &&
                           (cnt_r == sar_readout_pkg::CONV_LAST); // R10 R9
    assign rif.load_data = fmt_s ? {~i_conv_code[11], i_conv_code[10:0]}
                                 : i_conv_code; // R1 R18

    // Internal data clock burst during the conversion
    assign int_active = (state_r == sar_readout_pkg::ST_CONV) && int_mode_r &&
                        (cnt_r >= sar_readout_pkg::DCLK_DELAY) &&
                        (bits_r < sar_readout_pkg::DCLK_NUM);
    assign int_shift  = int_active && (phase_r == sar_readout_pkg::DCLK_HIGH);

    always_ff @(posedge i_clk) begin
        if (i_srst || state_r != sar_readout_pkg::ST_CONV) begin
            phase_r    <= '0;
            bits_r     <= '0;
            dclk_out_r <= 1'h0;
        end else if (int_active) begin
            dclk_out_r <= (phase_r < sar_readout_pkg::DCLK_HIGH); // R21
            if (phase_r == sar_readout_pkg::DCLK_PH_LAST) begin
                phase_r <= '0;
                bits_r  <= bits_r + BW'(1); // R21
            end else begin
                phase_r <= phase_r + BW'(1);
            end
        end else begin
            dclk_out_r <= 1'h0;
        end
    end

    // External clock: first rising edge presents the MSB, later ones shift
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            dclk_d_r <= 1'h0;
            first_r  <= 1'h1;
        end else begin
            dclk_d_r <= dclk_s;
            if (!ext_rd) begin
                first_r <= 1'h1;
            end else if (dclk_rise) begin
                first_r <= 1'h0;
            end
        end
    end

    assign dclk_rise    = dclk_s & ~dclk_d_r;
    assign ext_shift    = ext_rd & dclk_rise & ~first_r; // R14 R15
    assign rif.shift    = int_shift | ext_shift; // R2
    // Chained serial input is not supported; zeros follow the LSB
    assign rif.shift_in = 1'h0;

    // Parallel bus never shifts the register, it only looks at it
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            par_r      <= 8'h00;
            par_oe_n_r <= 1'h1;
        end else begin
            par_oe_n_r <= ~read_en; // R5
            if (byte_s) begin
                par_r <= {rif.data[3:0], 4'h0}; // R6 R7
            end else begin
                par_r <= rif.data[11:4]; // R6 R7
            end
        end
    end

    assign o_parallel_data_bus      = par_r;
    assign o_parallel_data_bus_oe_n = par_oe_n_r;
    assign o_serial_data_out        = rif.data[sar_readout_pkg::MSB_POS]; // R21
    assign o_serial_data_clock      = dclk_out_r; // R12
    assign o_serial_data_clock_oe_n = src_s; // R12 R13

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_srst);

    property p_format;
        rif.load |=> rif.data[11] == ($past(i_conv_code[11]) ^ $past(fmt_s));
    endproperty
    a_format: assert property (p_format) else $error("result format wrong"); // R1

    property p_bus_oe;
        1'h1 |=> o_parallel_data_bus_oe_n == !$past(read_en);
    endproperty
    a_bus_oe: assert property (p_bus_oe) else $error("bus enable wrong"); // R5

    property p_byte_lo;
        byte_s |=> o_parallel_data_bus == {$past(rif.data[3:0]), 4'h0};
    endproperty
    a_byte_lo: assert property (p_byte_lo) else $error("low byte wrong"); // R6

    property p_byte_hi;
        !byte_s |=> o_parallel_data_bus == $past(rif.data[11:4]);
    endproperty
    a_byte_hi: assert property (p_byte_hi) else $error("high byte wrong"); // R7

    property p_busy_after_load;
        rif.load |=> !o_busy_n ##1 o_busy_n;
    endproperty
    a_busy_after_load: assert property (p_busy_after_load) else $error("busy order"); // R9

    property p_hold_prev;
        rif.load |-> cnt_r >= sar_readout_pkg::HOLD_CNT;
    endproperty
    a_hold_prev: assert property (p_hold_prev) else $error("result replaced early"); // R10

    property p_ignore;
        (state_r == sar_readout_pkg::ST_CONV && cnt_r != sar_readout_pkg::CONV_LAST)
            |=> state_r == sar_readout_pkg::ST_CONV && cnt_r == $past(cnt_r) + CW'(1);
    endproperty
    a_ignore: assert property (p_ignore) else $error("command not ignored"); // R17

    property p_start;
        (o_busy_n && conv_req) |=> !o_busy_n [*8];
    endproperty
    a_start: assert property (p_start) else $error("start not taken"); // R20

    property p_int_pulses;
        (state_r == sar_readout_pkg::ST_UPDATE && int_mode_r) |-> bits_r == 4'hC;
    endproperty
    a_int_pulses: assert property (p_int_pulses) else $error("pulse count wrong"); // R21

    property p_ext_shift;
        (ext_shift && !rif.load) |=> rif.data == {$past(rif.data[10:0]), 1'h0};
    endproperty
    a_ext_shift: assert property (p_ext_shift) else $error("serial shift wrong"); // R14

    property p_stable;
        (!rif.load && !rif.shift) |=> $stable(rif.data);
    endproperty
    a_stable: assert property (p_stable) else $error("register changed"); // R22

    c_int_conv: cover property (state_r == sar_readout_pkg::ST_UPDATE && int_mode_r);
    c_ext_shift: cover property (ext_shift && !o_busy_n);
    c_byte_toggle: cover property (read_en && byte_s ##1 read_en && !byte_s);
    c_restart: cover property (state_r == sar_readout_pkg::ST_UPDATE ##1 conv_req);
endmodule

// ---- verif/host_model.sv ----
// Host side model: external data clock bursts and serial capture
`timescale 1ns/1ps
module host_model (
    // Serial pins
    input  wire logic i_serial_data_out,
    output logic      o_serial_data_clock
);
    // Clock stands low outside bursts, never free running
    initial o_serial_data_clock = 1'b0;
    // Bit taken late in the high phase, after the device shift lands
    task automatic burst(output logic [11:0] bits);
        int k;
        bits = 12'h000;
        for (k = 0; k < 12; k++) begin
            #400;
            o_serial_data_clock = 1'b1;
            #400;
            bits = {bits[10:0], i_serial_data_out};
            o_serial_data_clock = 1'b0;
        end
    endtask
endmodule

// ---- verif/testbench.sv ----
// Self-checking bench for the converter result readout
`timescale 1ns/1ps
module testbench;
    logic        i_clk = 1'b0;
    logic        i_srst = 1'b1;
    logic        i_cs_n = 1'b1;
    logic        i_rd_conv = 1'b1;
    logic        i_byte_sel = 1'b0;
    logic        i_fmt = 1'b0;
    logic        i_src = 1'b1;
    logic [11:0] i_conv_code = 12'h000;
    logic        ext_dclk;
    logic        dclk;
    logic        dclk_oe_n;
    logic        serial_data_out;
    logic [7:0]  bus;
    logic        bus_oe_n;
    logic        busy_n;
    logic        dclk_q = 1'b0;
    logic        have_prev = 1'b0;
    logic [11:0] prev;
    logic [11:0] last;
    logic [11:0] got;
    logic [11:0] ser_bits;
    logic [11:0] codes [4] = '{12'h7FF, 12'h000, 12'hFFF, 12'h800};
    int          busy_len = 0;
    int          ser_pulses = 0;
    int          n_mismatch = 0;
    int          n_checks = 0;

    always #50 i_clk = ~i_clk;

    sar_adc_result_readout uut (
        .i_clk(i_clk), .i_srst(i_srst), .i_cs_n(i_cs_n), .i_rd_conv(i_rd_conv),
        .i_byte_sel(i_byte_sel), .i_output_format_select(i_fmt),
        .i_data_clock_source_select(i_src), .i_serial_data_clock(ext_dclk),
        .o_serial_data_clock(dclk), .o_serial_data_clock_oe_n(dclk_oe_n),
        .o_serial_data_out(serial_data_out), .o_parallel_data_bus(bus),
        .o_parallel_data_bus_oe_n(bus_oe_n), .o_busy_n(busy_n), .i_conv_code(i_conv_code)
    );

    host_model host (
        .i_serial_data_out(serial_data_out),
        .o_serial_data_clock(ext_dclk)
    );

    // Busy length and internal clock capture, sampled on settled values
    always @(negedge i_clk) begin
        if (busy_n === 1'b0) busy_len++;
        if (dclk === 1'b1 && dclk_q === 1'b0) begin
            ser_bits = {ser_bits[10:0], serial_data_out};
            ser_pulses++;
        end
        dclk_q = dclk;
    end

    task automatic complete_run();
        if (n_mismatch == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic check(input string name, input logic [11:0] seen, input logic [11:0] exp);
        n_checks++;
        if (seen !== exp) begin
            $display("mismatch %s expected %h seen %h", name, exp, seen);
            n_mismatch++;
        end
    endtask

    task automatic read_bus(input logic bs, input logic [11:0] d);
        @(negedge i_clk);
        i_cs_n = 1'b0;
        i_rd_conv = 1'b1;
        i_byte_sel = bs;
        repeat (4) @(negedge i_clk);
        check("bus_oe_n", {11'h000, bus_oe_n}, 12'h000);
        check("bus", {4'h0, bus}, {4'h0, bs ? {d[3:0], 4'h0} : d[11:4]});
    endtask

    // Mode 0: parallel with retrigger, 1: internal serial, 2: external read during conversion
    task automatic convert(input logic [11:0] code, input logic fmt, input logic src,
                           input int mode);
        int k;
        @(negedge i_clk);
        i_conv_code = code;
        i_fmt = fmt;
        i_src = src;
        i_byte_sel = 1'b0;
        i_rd_conv = 1'b0;
        busy_len = 0;
        ser_pulses = 0;
        @(negedge i_clk);
        i_cs_n = 1'b0;
        repeat (4) @(negedge i_clk);
        check("busy_start", {11'h000, busy_n}, 12'h000);
        check("bus_conv", {11'h000, bus_oe_n}, 12'h001);
        check("dclk_oe_n", {11'h000, dclk_oe_n}, {11'h000, src});
        i_rd_conv = 1'b1;
        if (mode == 2) begin
            host.burst(got);
            check("ser_prev", got, prev);
        end else if (mode == 0) begin
            repeat (20) @(negedge i_clk);
            if (have_prev) check("bus_prev", {4'h0, bus}, {4'h0, prev[11:4]});
            i_rd_conv = 1'b0;
            repeat (3) @(negedge i_clk);
            i_rd_conv = 1'b1;
        end
        k = 0;
        while (busy_n !== 1'b1 && k < 400) begin
            @(negedge i_clk);
            k++;
        end
        if (k == 400) begin
            n_mismatch++;
            complete_run();
        end
        check("busy_len", 12'(busy_len), 12'h094);
        prev = fmt ? {~code[11], code[10:0]} : code;
        have_prev = 1'b1;
        repeat (5) @(negedge i_clk);
        check("busy_after", {11'h000, busy_n}, 12'h001);
    endtask

    initial begin
        int f;
        int i;
        repeat (5) @(posedge i_clk);
        @(negedge i_clk);
        i_srst = 1'b0;
        repeat (3) @(negedge i_clk);
        check("busy_rst", {11'h000, busy_n}, 12'h001);
        check("oe_rst", {11'h000, bus_oe_n}, 12'h001);
        for (f = 0; f < 2; f++) begin
            for (i = 0; i < 4; i++) begin
                convert(codes[i], f[0], 1'b1, 0);
                read_bus(1'b0, prev);
                read_bus(1'b1, prev);
                read_bus(1'b0, prev);
                @(negedge i_clk);
                i_cs_n = 1'b1;
                repeat (4) @(negedge i_clk);
                check("oe_idle", {11'h000, bus_oe_n}, 12'h001);
            end
        end
        convert(12'h9E6, 1'b1, 1'b1, 0);
        last = prev;
        convert(12'h5A3, 1'b0, 1'b0, 1);
        check("ser_pulses", 12'(ser_pulses), 12'h00C);
        check("ser_bits", ser_bits, last);
        read_bus(1'b0, prev);
        convert(12'h3C7, 1'b1, 1'b1, 2);
        @(negedge i_clk);
        i_cs_n = 1'b1;
        repeat (4) @(negedge i_clk);
        read_bus(1'b0, prev);
        host.burst(got);
        check("ser_done", got, prev);
        read_bus(1'b0, {prev[0], 11'h000});
        complete_run();
    end
endmodule
